// ==== hw/pfsm_map.vh ====
`ifndef PFSM_MAP_VH
`define PFSM_MAP_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define PFSM_ADDR_W        5
`define PFSM_NUM_REGS      18
`define PFSM_ADDR_PB_LOW   5'h00
`define PFSM_ADDR_PB_HIGH  5'h01
`define PFSM_ADDR_PC_LOW   5'h02
`define PFSM_ADDR_PC_HIGH  5'h03
`define PFSM_ADDR_PD_LOW   5'h04
`define PFSM_ADDR_PD_HIGH  5'h05
`define PFSM_ADDR_PE_LOW   5'h06
`define PFSM_ADDR_PE_HIGH  5'h07
`define PFSM_ADDR_PF_LOW   5'h08
`define PFSM_ADDR_PF_HIGH  5'h09
`define PFSM_ADDR_PG_LOW   5'h0A
`define PFSM_ADDR_PG_HIGH  5'h0B
`define PFSM_ADDR_PH_LOW   5'h0C
`define PFSM_ADDR_PH_HIGH  5'h0D
`define PFSM_ADDR_TCK_SRC  5'h0E
`define PFSM_ADDR_CAP_SRC  5'h0F
`define PFSM_ADDR_SER_SRC  5'h10
`define PFSM_ADDR_RX_SRC   5'h11

// ----------------------------------------
// reset value and implemented-bit masks
// ----------------------------------------
`define PFSM_SEL_RESET     8'h00
`define PFSM_MASK_FULL     8'hFF
`define PFSM_MASK_PD_HIGH  8'h3F
`define PFSM_MASK_PE_HIGH  8'h03
`define PFSM_MASK_PH_HIGH  8'h0F
`define PFSM_MASK_SRC      8'h7F
`define PFSM_MASK_RX_SMALL 8'h03
`define PFSM_MASK_RX_LARGE 8'h07

// ----------------------------------------
// field positions (lsb of 2-bit field)
// ----------------------------------------
`define PFSM_FLD_PB3       6
`define PFSM_FLD_PB2       4
`define PFSM_FLD_PB6       4
`define PFSM_FLD_PB5       2
`define PFSM_FLD_PC1       2
`define PFSM_FLD_PC0       0
`define PFSM_FLD_PD2       4
`define PFSM_FLD_PD4       0
`define PFSM_FLD_PE4       0
`define PFSM_FLD_PF7       6
`define PFSM_FLD_PG0       0
`define PFSM_FLD_PG1       2
`define PFSM_FLD_PH2       4
`define PFSM_FLD_PH3       6
`define PFSM_FLD_PH4       0
`define PFSM_FLD_PH5       2

// ----------------------------------------
// managed pin indices
// ----------------------------------------
`define PFSM_NUM_PINS      20
`define PFSM_PIN_PB3       0
`define PFSM_PIN_PB2       1
`define PFSM_PIN_PB6       2
`define PFSM_PIN_PB5       3
`define PFSM_PIN_PC1       4
`define PFSM_PIN_PC0       5
`define PFSM_PIN_PD2       6
`define PFSM_PIN_PD4       7
`define PFSM_PIN_PE4       8
`define PFSM_PIN_PF0       9
`define PFSM_PIN_PF7       13
`define PFSM_PIN_PG0       14
`define PFSM_PIN_PG1       15
`define PFSM_PIN_PH2       16

// ----------------------------------------
// field codes
// ----------------------------------------
`define PFSM_CODE_0        2'b00
`define PFSM_CODE_1        2'b01
`define PFSM_CODE_2        2'b10
`define PFSM_CODE_3        2'b11

`endif

// ==== hw/pfsm_pin_mux.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pfsm_map.vh"

module pfsm_pin_mux #(
    parameter LARGE_VARIANT = 1
) (
    input  wire                         clk_in,
    input  wire                         rst_in,
    input  wire [`PFSM_ADDR_W-1:0]      addr_in,
    input  wire [7:0]                   wr_data_in,
    input  wire                         wr_in,
    input  wire                         rd_in,
    output reg  [7:0]                   rd_data_out,
    input  wire [7:0]                   port_a_pin_in,
    input  wire [7:0]                   port_b_pin_in,
    input  wire [7:0]                   port_c_pin_in,
    input  wire [7:0]                   port_d_pin_in,
    input  wire [7:0]                   port_e_pin_in,
    input  wire [7:0]                   port_f_pin_in,
    input  wire [7:0]                   port_g_pin_in,
    input  wire [`PFSM_NUM_PINS-1:0]    pin_gpio_do_in,
    input  wire [`PFSM_NUM_PINS-1:0]    pin_gpio_oe_n_in,
    input  wire                         periodic_timer2_output_in,
    input  wire                         periodic_timer3_output_in,
    input  wire                         standard_timer1_output_in,
    input  wire                         standard_timer2_output_in,
    input  wire                         comparator0_output_in,
    input  wire                         uart1_transmit_in,
    input  wire                         uart2_transmit_in,
    input  wire [3:0]                   serial_pin_do_in,
    input  wire [3:0]                   serial_pin_oe_n_in,
    input  wire [3:0]                   lcd_common_in,
    output reg  [`PFSM_NUM_PINS-1:0]    pin_do_out,
    output reg  [`PFSM_NUM_PINS-1:0]    pin_oe_n_out,
    output reg  [`PFSM_NUM_PINS-1:0]    pin_special_out,
    output reg  [3:0]                   ptm_clock_out,
    output reg  [2:0]                   stm_clock_out,
    output reg  [3:0]                   ptm_capture_out,
    output reg  [2:0]                   stm_capture_out,
    output reg                          serial_cs_out,
    output reg                          serial_data_in_out,
    output reg                          serial_clock_out,
    output reg  [3:0]                   ext_int_out,
    output reg  [2:0]                   uart_receive_out
);

// ----------------------------------------
// selection registers
// ----------------------------------------
reg  [7:0] sel_r [0:`PFSM_NUM_REGS-1];
integer    i;

function [7:0] impl_mask;
    input [`PFSM_ADDR_W-1:0] a;
    begin
        case (a)
            `PFSM_ADDR_PD_HIGH: impl_mask = `PFSM_MASK_PD_HIGH;
            `PFSM_ADDR_PE_HIGH: impl_mask = `PFSM_MASK_PE_HIGH;
            `PFSM_ADDR_PH_HIGH: impl_mask = `PFSM_MASK_PH_HIGH;
            `PFSM_ADDR_TCK_SRC: impl_mask = `PFSM_MASK_SRC;
            `PFSM_ADDR_CAP_SRC: impl_mask = `PFSM_MASK_SRC;
            `PFSM_ADDR_SER_SRC: impl_mask = `PFSM_MASK_SRC;
            `PFSM_ADDR_RX_SRC:  impl_mask = (LARGE_VARIANT != 0) ?
                                    `PFSM_MASK_RX_LARGE : `PFSM_MASK_RX_SMALL;
            default: begin
                if (a < `PFSM_NUM_REGS) begin
                    impl_mask = `PFSM_MASK_FULL;
                end else begin
                    impl_mask = 8'h00;
                end
            end
        endcase
    end
endfunction

always @(posedge clk_in) begin
    if (rst_in) begin
        for (i = 0; i < `PFSM_NUM_REGS; i = i + 1) begin
            sel_r[i] <= `PFSM_SEL_RESET;
        end
    end else if (wr_in && (addr_in < `PFSM_NUM_REGS)) begin
        sel_r[addr_in] <= wr_data_in & impl_mask(addr_in);
    end
end

// ----------------------------------------
// register read
// ----------------------------------------
// data stands one cycle, zero otherwise
always @(posedge clk_in) begin
    if (rst_in) begin
        rd_data_out <= 8'h00;
    end else if (rd_in && (addr_in < `PFSM_NUM_REGS)) begin
        rd_data_out <= sel_r[addr_in] & impl_mask(addr_in);
    end else begin
        rd_data_out <= 8'h00;
    end
end

// ----------------------------------------
// field extraction
// ----------------------------------------
wire [1:0] f_pb3 = sel_r[`PFSM_ADDR_PB_LOW][`PFSM_FLD_PB3 +: 2];
wire [1:0] f_pb2 = sel_r[`PFSM_ADDR_PB_LOW][`PFSM_FLD_PB2 +: 2];
wire [1:0] f_pb6 = sel_r[`PFSM_ADDR_PB_HIGH][`PFSM_FLD_PB6 +: 2];
wire [1:0] f_pc1 = sel_r[`PFSM_ADDR_PC_LOW][`PFSM_FLD_PC1 +: 2];
wire [1:0] f_pc0 = sel_r[`PFSM_ADDR_PC_LOW][`PFSM_FLD_PC0 +: 2];
wire [1:0] f_pd2 = sel_r[`PFSM_ADDR_PD_LOW][`PFSM_FLD_PD2 +: 2];
wire [1:0] f_pd4 = sel_r[`PFSM_ADDR_PD_HIGH][`PFSM_FLD_PD4 +: 2];
wire [1:0] f_pe4 = sel_r[`PFSM_ADDR_PE_HIGH][`PFSM_FLD_PE4 +: 2];
wire [7:0] f_pf0 = sel_r[`PFSM_ADDR_PF_LOW];
wire [1:0] f_pf7 = sel_r[`PFSM_ADDR_PF_HIGH][`PFSM_FLD_PF7 +: 2];
wire [1:0] f_pg0 = sel_r[`PFSM_ADDR_PG_LOW][`PFSM_FLD_PG0 +: 2];
wire [1:0] f_pg1 = sel_r[`PFSM_ADDR_PG_LOW][`PFSM_FLD_PG1 +: 2];
wire [7:0] f_ph  = {sel_r[`PFSM_ADDR_PH_HIGH][`PFSM_FLD_PH5 +: 2],
                    sel_r[`PFSM_ADDR_PH_HIGH][`PFSM_FLD_PH4 +: 2],
                    sel_r[`PFSM_ADDR_PH_LOW][`PFSM_FLD_PH3 +: 2],
                    sel_r[`PFSM_ADDR_PH_LOW][`PFSM_FLD_PH2 +: 2]};

// ----------------------------------------
// output function decode
// ----------------------------------------
reg [`PFSM_NUM_PINS-1:0] do_nxt;
reg [`PFSM_NUM_PINS-1:0] oe_n_nxt;
reg [`PFSM_NUM_PINS-1:0] sp_nxt;
integer k;

always @* begin
    // port_b_line5 is the only pin that stays on this default path in every setting when LARGE_VARIANT is nonzero
    do_nxt   = pin_gpio_do_in;
    oe_n_nxt = pin_gpio_oe_n_in;
    sp_nxt   = {`PFSM_NUM_PINS{1'b0}};
    if (f_pb3 == `PFSM_CODE_3) begin
        do_nxt[`PFSM_PIN_PB3]   = periodic_timer2_output_in;
        oe_n_nxt[`PFSM_PIN_PB3] = 1'b0;
    end
    if (f_pb2 == `PFSM_CODE_3) begin
        do_nxt[`PFSM_PIN_PB2]   = periodic_timer3_output_in;
        oe_n_nxt[`PFSM_PIN_PB2] = 1'b0;
    end else if ((f_pb2 == `PFSM_CODE_2) && (LARGE_VARIANT != 0)) begin
        do_nxt[`PFSM_PIN_PB2]   = 1'b0;
        oe_n_nxt[`PFSM_PIN_PB2] = 1'b1;
    end
    case (f_pb6)
        `PFSM_CODE_2: begin
            do_nxt[`PFSM_PIN_PB6]   = standard_timer1_output_in;
            oe_n_nxt[`PFSM_PIN_PB6] = 1'b0;
        end
        `PFSM_CODE_3: begin
            do_nxt[`PFSM_PIN_PB6]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PB6] = 1'b1;
            sp_nxt[`PFSM_PIN_PB6]   = 1'b1;
        end
        default: begin
        end
    endcase
    case (f_pc1)
        `PFSM_CODE_1: begin
            do_nxt[`PFSM_PIN_PC1]   = comparator0_output_in;
            oe_n_nxt[`PFSM_PIN_PC1] = 1'b0;
        end
        `PFSM_CODE_2, `PFSM_CODE_3: begin
            do_nxt[`PFSM_PIN_PC1]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PC1] = 1'b1;
            sp_nxt[`PFSM_PIN_PC1]   = 1'b1;
        end
        default: begin
        end
    endcase
    if (f_pc0[1]) begin
        do_nxt[`PFSM_PIN_PC0]   = 1'b0;
        oe_n_nxt[`PFSM_PIN_PC0] = 1'b1;
        sp_nxt[`PFSM_PIN_PC0]   = 1'b1;
    end
    case (f_pd2)
        `PFSM_CODE_1: begin
            do_nxt[`PFSM_PIN_PD2]   = periodic_timer2_output_in;
            oe_n_nxt[`PFSM_PIN_PD2] = 1'b0;
        end
        `PFSM_CODE_2: begin
            do_nxt[`PFSM_PIN_PD2]   = uart1_transmit_in;
            oe_n_nxt[`PFSM_PIN_PD2] = 1'b0;
        end
        `PFSM_CODE_3: begin
            do_nxt[`PFSM_PIN_PD2]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PD2] = 1'b1;
            sp_nxt[`PFSM_PIN_PD2]   = 1'b1;
        end
        default: begin
        end
    endcase
    case (f_pd4)
        `PFSM_CODE_1: begin
            do_nxt[`PFSM_PIN_PD4]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PD4] = 1'b1;
        end
        `PFSM_CODE_2: begin
            do_nxt[`PFSM_PIN_PD4]   = periodic_timer3_output_in;
            oe_n_nxt[`PFSM_PIN_PD4] = 1'b0;
        end
        `PFSM_CODE_3: begin
            do_nxt[`PFSM_PIN_PD4]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PD4] = 1'b1;
            sp_nxt[`PFSM_PIN_PD4]   = 1'b1;
        end
        default: begin
        end
    endcase
    if (f_pe4 == `PFSM_CODE_3) begin
        do_nxt[`PFSM_PIN_PE4]   = 1'b0;
        oe_n_nxt[`PFSM_PIN_PE4] = 1'b1;
        sp_nxt[`PFSM_PIN_PE4]   = 1'b1;
    end
    for (k = 0; k < 4; k = k + 1) begin
        if (f_pf0[2*k +: 2] == `PFSM_CODE_2) begin
            do_nxt[`PFSM_PIN_PF0 + k]   = serial_pin_do_in[k];
            oe_n_nxt[`PFSM_PIN_PF0 + k] = serial_pin_oe_n_in[k];
        end else if (f_pf0[2*k +: 2] == `PFSM_CODE_3) begin
            do_nxt[`PFSM_PIN_PF0 + k]   = lcd_common_in[k];
            oe_n_nxt[`PFSM_PIN_PF0 + k] = 1'b0;
        end
        if (f_ph[2*k +: 2] == `PFSM_CODE_3) begin
            do_nxt[`PFSM_PIN_PH2 + k]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PH2 + k] = 1'b1;
            sp_nxt[`PFSM_PIN_PH2 + k]   = 1'b1;
        end
    end
    case (f_pf7)
        `PFSM_CODE_1: begin
            do_nxt[`PFSM_PIN_PF7]   = uart1_transmit_in;
            oe_n_nxt[`PFSM_PIN_PF7] = 1'b0;
        end
        `PFSM_CODE_2: begin
            do_nxt[`PFSM_PIN_PF7]   = standard_timer2_output_in;
            oe_n_nxt[`PFSM_PIN_PF7] = 1'b0;
        end
        `PFSM_CODE_3: begin
            do_nxt[`PFSM_PIN_PF7]   = 1'b0;
            oe_n_nxt[`PFSM_PIN_PF7] = 1'b1;
            sp_nxt[`PFSM_PIN_PF7]   = 1'b1;
        end
        default: begin
        end
    endcase
    if ((f_pg0 == `PFSM_CODE_3) && (LARGE_VARIANT != 0)) begin
        do_nxt[`PFSM_PIN_PG0]   = 1'b0;
        oe_n_nxt[`PFSM_PIN_PG0] = 1'b1;
    end
    if ((f_pg1 == `PFSM_CODE_3) && (LARGE_VARIANT != 0)) begin
        do_nxt[`PFSM_PIN_PG1]   = uart2_transmit_in;
        oe_n_nxt[`PFSM_PIN_PG1] = 1'b0;
    end
end

// ----------------------------------------
// input source routing
// ----------------------------------------
wire [6:0] tck_src = sel_r[`PFSM_ADDR_TCK_SRC][6:0];
wire [6:0] cap_src = sel_r[`PFSM_ADDR_CAP_SRC][6:0];
wire [6:0] ser_src = sel_r[`PFSM_ADDR_SER_SRC][6:0];
wire [2:0] rx_src  = sel_r[`PFSM_ADDR_RX_SRC][2:0];

wire [6:0] tck_pri = {port_d_pin_in[5], port_d_pin_in[3], port_c_pin_in[5], port_c_pin_in[3],
                      port_f_pin_in[6], port_d_pin_in[1], port_c_pin_in[7]};
wire [6:0] tck_alt = {port_b_pin_in[1], port_b_pin_in[2], port_e_pin_in[2], port_f_pin_in[4],
                      port_b_pin_in[0], port_b_pin_in[7], port_e_pin_in[0]};
wire [6:0] cap_pri = {port_d_pin_in[4], port_d_pin_in[2], port_c_pin_in[4], port_c_pin_in[2],
                      port_d_pin_in[6], port_d_pin_in[0], port_c_pin_in[6]};
wire [6:0] cap_alt = {port_b_pin_in[2], port_b_pin_in[3], port_e_pin_in[3], port_f_pin_in[5],
                      port_f_pin_in[7], port_b_pin_in[6], port_e_pin_in[1]};
wire [6:0] ser_pri = {port_a_pin_in[1], port_a_pin_in[4], port_a_pin_in[5], port_a_pin_in[5],
                      port_a_pin_in[4], port_a_pin_in[3], port_a_pin_in[1]};
wire [6:0] ser_alt = {port_f_pin_in[0], port_f_pin_in[2], port_f_pin_in[3], port_c_pin_in[7],
                      port_d_pin_in[0], port_a_pin_in[7], port_a_pin_in[6]};
wire [2:0] rx_pri  = {port_b_pin_in[2], port_d_pin_in[1], port_a_pin_in[6]};
wire [2:0] rx_alt  = {port_g_pin_in[0], port_f_pin_in[6], port_d_pin_in[4]};

// a set source bit picks the alternate pin
wire [6:0] tck_nxt = (tck_src & tck_alt) | (~tck_src & tck_pri);
wire [6:0] cap_nxt = (cap_src & cap_alt) | (~cap_src & cap_pri);
wire [6:0] ser_nxt = (ser_src & ser_alt) | (~ser_src & ser_pri);
wire [2:0] rx_nxt  = (rx_src & rx_alt) | (~rx_src & rx_pri);

// ----------------------------------------
// output registers
// ----------------------------------------
always @(posedge clk_in) begin
    if (rst_in) begin
        pin_do_out         <= {`PFSM_NUM_PINS{1'b0}};
        pin_oe_n_out       <= {`PFSM_NUM_PINS{1'b1}};
        pin_special_out    <= {`PFSM_NUM_PINS{1'b0}};
        ptm_clock_out      <= 4'h0;
        stm_clock_out      <= 3'h0;
        ptm_capture_out    <= 4'h0;
        stm_capture_out    <= 3'h0;
        serial_cs_out      <= 1'b0;
        serial_data_in_out <= 1'b0;
        serial_clock_out   <= 1'b0;
        ext_int_out        <= 4'h0;
        uart_receive_out   <= 3'h0;
    end else begin
        pin_do_out         <= do_nxt;
        pin_oe_n_out       <= oe_n_nxt;
        pin_special_out    <= sp_nxt;
        ptm_clock_out      <= tck_nxt[6:3];
        stm_clock_out      <= tck_nxt[2:0];
        ptm_capture_out    <= cap_nxt[6:3];
        stm_capture_out    <= cap_nxt[2:0];
        serial_cs_out      <= ser_nxt[6];
        serial_data_in_out <= ser_nxt[5];
        serial_clock_out   <= ser_nxt[4];
        ext_int_out        <= ser_nxt[3:0];
        uart_receive_out   <= rx_nxt;
    end
end

endmodule // pfsm_pin_mux

`default_nettype wire

// ==== hw/dummy_unused_placeholder_never.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/pfsm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// checker
// --------
module pfsm_monitor #(
    parameter LARGE_VARIANT = 1
) (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [4:0]  addr_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic [7:0]  port_b_pin_in,
    input wire logic [7:0]  port_d_pin_in,
    input wire logic [7:0]  port_g_pin_in,
    input wire logic [19:0] pin_gpio_do_in,
    input wire logic [19:0] pin_gpio_oe_n_in,
    input wire logic        periodic_timer2_output_in,
    input wire logic [19:0] pin_do_out,
    input wire logic [19:0] pin_oe_n_out,
    input wire logic [19:0] pin_special_out,
    input wire logic [3:0]  ptm_clock_out,
    input wire logic [3:0]  ptm_capture_out,
    input wire logic [2:0]  uart_receive_out
);
    logic [7:0] pbl_r, tck_r, cap_r, rx_r;
    logic       e_tck, e_cap, e_rx2, e_pb3;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // shadow copies of the PB low, timer clock, capture and receive selection registers
    always @(posedge clk_in) begin
        if (rst_in) begin
            pbl_r <= 8'h00;
            tck_r <= 8'h00;
            cap_r <= 8'h00;
            rx_r  <= 8'h00;
        end else if (wr_in) begin
            case (addr_in)
                5'h00: pbl_r <= wr_data_in;
                5'h0E: tck_r <= wr_data_in;
                5'h0F: cap_r <= wr_data_in;
                5'h11: rx_r  <= wr_data_in;
                default: ;
            endcase
        end
    end

    assign e_tck = tck_r[6] ? port_b_pin_in[1] : port_d_pin_in[5];
    assign e_cap = cap_r[6] ? port_b_pin_in[2] : port_d_pin_in[4];
    assign e_rx2 = (LARGE_VARIANT != 0 && rx_r[2]) ? port_g_pin_in[0] : port_b_pin_in[2];
    assign e_pb3 = (pbl_r[7:6] == 2'b11) ? periodic_timer2_output_in : pin_gpio_do_in[0];

    tck_route_a: assert property (!$past(rst_in) |-> ptm_clock_out[3] == $past(e_tck))
        else $error("timer clock 3 source wrong");
    cap_route_a: assert property (!$past(rst_in) |-> ptm_capture_out[3] == $past(e_cap))
        else $error("capture 3 source wrong");
    rx_route_a: assert property (!$past(rst_in) |-> uart_receive_out[2] == $past(e_rx2))
        else $error("uart 2 receive source wrong");
    pb5_plain_a: assert property (!$past(rst_in) |-> !pin_special_out[3] &&
        pin_oe_n_out[3] == $past(pin_gpio_oe_n_in[3]) && pin_do_out[3] == $past(pin_gpio_do_in[3]))
        else $error("port b line 5 not plain");
    pb3_drive_a: assert property (!$past(rst_in) |-> pin_do_out[0] == $past(e_pb3))
        else $error("port b line 3 drive wrong");
    reset_clear_a: assert property ($past(rst_in) |-> pin_special_out == 20'h00000 &&
        pin_oe_n_out == 20'hFFFFF && ptm_clock_out == 4'h0)
        else $error("outputs not cleared by reset");
    rd_idle_a: assert property (!rd_in |=> rd_data_out == 8'h00)
        else $error("read data without read");
    rd_unmapped_a: assert property (rd_in && addr_in > 5'h11 |=> rd_data_out == 8'h00)
        else $error("unmapped read not zero");

    cover property (rd_in ##1 rd_data_out != 8'h00);
    cover property (tck_r[6] && $rose(ptm_clock_out[3]));
    cover property (pin_special_out[4]);
endmodule // pfsm_monitor

bind pfsm_pin_mux pfsm_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) pfsm_monitor_inst (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .port_b_pin_in(port_b_pin_in), .port_d_pin_in(port_d_pin_in),
    .port_g_pin_in(port_g_pin_in), .pin_gpio_do_in(pin_gpio_do_in),
    .pin_gpio_oe_n_in(pin_gpio_oe_n_in),
    .periodic_timer2_output_in(periodic_timer2_output_in), .pin_do_out(pin_do_out),
    .pin_oe_n_out(pin_oe_n_out), .pin_special_out(pin_special_out),
    .ptm_clock_out(ptm_clock_out), .ptm_capture_out(ptm_capture_out),
    .uart_receive_out(uart_receive_out)
);
`default_nettype wire

// ==== verification/pfsm_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// pads
// --------
module pfsm_partner (
    input  wire logic        clk_in,
    input  wire logic        freeze_in,
    input  wire logic [19:0] pin_do_in,
    input  wire logic [19:0] pin_oe_n_in,
    output logic      [55:0] pad_out
);
    localparam int PAD_IDX [16] = '{11, 10, 14, 13, 17, 16, 26, 28,
                                    36, 40, 41, 42, 43, 47, 48, 49};
    logic [55:0] level_r = 56'h9A3C5E71D2B846;

    // undriven pads wander every cycle unless frozen
    always @(posedge clk_in) begin
        if (!freeze_in) begin
            level_r <= {level_r[54:0], ~(level_r[55] ^ level_r[38])};
        end
    end

    // a pad driven by one of the mux's first 16 pins shows the driven level
    always_comb begin
        pad_out = level_r;
        for (int i = 0; i < 16; i++) begin
            if (!pin_oe_n_in[i]) begin
                pad_out[PAD_IDX[i]] = pin_do_in[i];
            end
        end
    end
endmodule // pfsm_partner
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] MSK [18] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h7F, 8'h7F, 8'h7F, 8'h07};
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [4:0]  addr_in = 5'h00;
    logic [7:0]  wr_data_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [19:0] gpio_do = 20'h00000;
    logic [19:0] gpio_oe_n = 20'h00000;
    logic        lvl = 1'b1;
    logic        freeze = 1'b0;
    logic [7:0]  rd_data_out;
    logic [19:0] pin_do_out, pin_oe_n_out, pin_special_out;
    logic [3:0]  ptm_clock_out, ptm_capture_out, ext_int_out;
    logic [2:0]  stm_clock_out, stm_capture_out, uart_receive_out;
    logic        sdi, scs, sck;
    logic [55:0] pad;
    int          err_total = 0;
    int          comparisons = 0;

    always #20 clk_in = ~clk_in;

    pfsm_pin_mux #(.LARGE_VARIANT(1)) pfsm_pin_mux_inst (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .port_a_pin_in(pad[7:0]), .port_b_pin_in(pad[15:8]), .port_c_pin_in(pad[23:16]),
        .port_d_pin_in(pad[31:24]), .port_e_pin_in(pad[39:32]), .port_f_pin_in(pad[47:40]),
        .port_g_pin_in(pad[55:48]), .pin_gpio_do_in(gpio_do), .pin_gpio_oe_n_in(gpio_oe_n),
        .periodic_timer2_output_in(lvl), .periodic_timer3_output_in(lvl),
        .standard_timer1_output_in(lvl), .standard_timer2_output_in(lvl),
        .comparator0_output_in(lvl), .uart1_transmit_in(~lvl), .uart2_transmit_in(lvl),
        .serial_pin_do_in({4{lvl}}), .serial_pin_oe_n_in({4{~lvl}}), .lcd_common_in({4{~lvl}}),
        .pin_do_out(pin_do_out), .pin_oe_n_out(pin_oe_n_out), .pin_special_out(pin_special_out),
        .ptm_clock_out(ptm_clock_out), .stm_clock_out(stm_clock_out),
        .ptm_capture_out(ptm_capture_out), .stm_capture_out(stm_capture_out),
        .serial_cs_out(scs), .serial_data_in_out(sdi), .serial_clock_out(sck),
        .ext_int_out(ext_int_out), .uart_receive_out(uart_receive_out)
    );

    pfsm_partner pfsm_partner_inst (.clk_in(clk_in), .freeze_in(freeze),
        .pin_do_in(pin_do_out), .pin_oe_n_in(pin_oe_n_out), .pad_out(pad));

    // --------
    // tasks
    // --------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rd_data_out, e);
    endtask

    task automatic read_all(input logic zero);
        for (int i = 0; i < 18; i++) rd(5'(i), zero ? 8'h00 : MSK[i]);
    endtask

    // pin state {data, enable_n, special} two cycles after the write
    task automatic pc(input logic [4:0] a, input logic [7:0] d, input int p, input logic [2:0] e);
        wr(a, d);
        repeat (2) @(posedge clk_in);
        #1 check({5'h00, pin_do_out[p], pin_oe_n_out[p], pin_special_out[p]}, {5'h00, e});
    endtask

    task automatic route(input logic s);
        logic [7:0] e;
        logic [23:0] f;
        wr(5'h0E, s ? 8'h7F : 8'h00);
        wr(5'h0F, s ? 8'h7F : 8'h00);
        wr(5'h10, s ? 8'h7F : 8'h00);
        wr(5'h11, s ? 8'h07 : 8'h00);
        freeze <= 1'b1;
        repeat (3) @(posedge clk_in);
        e = {s ? pad[9] : pad[29], s ? pad[10] : pad[28], s ? pad[7] : pad[3],
             s ? pad[42] : pad[4], s ? pad[48] : pad[10], s ? pad[28] : pad[6],
             s ? pad[32] : pad[23], s ? pad[47] : pad[30]};
        f = s ? {pad[9], pad[10], pad[34], pad[44], pad[8], pad[15], pad[32],
                 pad[10], pad[11], pad[35], pad[45], pad[47], pad[14], pad[33],
                 pad[40], pad[42], pad[43], pad[23], pad[24], pad[7], pad[6],
                 pad[48], pad[46], pad[28]}
              : {pad[29], pad[27], pad[21], pad[19], pad[46], pad[25], pad[23],
                 pad[28], pad[26], pad[20], pad[18], pad[30], pad[24], pad[22],
                 pad[1], pad[4], pad[5], pad[5], pad[4], pad[3], pad[1],
                 pad[10], pad[25], pad[6]};
        #1 check({ptm_clock_out[3], ptm_capture_out[3], ext_int_out[1], sdi,
                  uart_receive_out[2], uart_receive_out[0], stm_clock_out[0], stm_capture_out[2]}, e);
        check({ptm_clock_out, stm_clock_out, ptm_capture_out, stm_capture_out,
               scs, sdi, sck, ext_int_out, uart_receive_out}, f);
        @(posedge clk_in);
        freeze <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask

    task automatic do_reset;
        rst_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------
    // sequence
    // --------
    initial begin
        do_reset();
        read_all(1'b1);
        for (int i = 0; i < 18; i++) wr(5'(i), 8'hFF);
        read_all(1'b0);
        wr(5'h12, 8'hFF);
        rd(5'h12, 8'h00);
        rd(5'h1F, 8'h00);
        $display("test registers done");
        @(posedge clk_in);
        gpio_oe_n <= 20'hFFFFF;
        gpio_do <= 20'hFFFFF;
        pc(5'h00, 8'h80, 0, 3'h6);
        pc(5'h00, 8'hC0, 0, 3'h4);
        pc(5'h00, 8'h20, 1, 3'h2);
        pc(5'h00, 8'h30, 1, 3'h4);
        pc(5'h01, 8'h20, 2, 3'h4);
        pc(5'h01, 8'h30, 2, 3'h3);
        pc(5'h01, 8'h0C, 3, 3'h6);
        pc(5'h02, 8'h04, 4, 3'h4);
        pc(5'h02, 8'h08, 4, 3'h3);
        pc(5'h02, 8'h0C, 4, 3'h3);
        pc(5'h02, 8'h01, 5, 3'h6);
        pc(5'h02, 8'h02, 5, 3'h3);
        pc(5'h02, 8'h03, 5, 3'h3);
        pc(5'h04, 8'h10, 6, 3'h4);
        pc(5'h04, 8'h20, 6, 3'h0);
        pc(5'h04, 8'h30, 6, 3'h3);
        pc(5'h05, 8'h01, 7, 3'h2);
        pc(5'h05, 8'h02, 7, 3'h4);
        pc(5'h05, 8'h03, 7, 3'h3);
        pc(5'h07, 8'h02, 8, 3'h6);
        pc(5'h07, 8'h03, 8, 3'h3);
        pc(5'h08, 8'hAA, 12, 3'h4);
        pc(5'h08, 8'hFF, 9, 3'h0);
        pc(5'h09, 8'h40, 13, 3'h0);
        pc(5'h09, 8'h80, 13, 3'h4);
        pc(5'h09, 8'hC0, 13, 3'h3);
        pc(5'h0A, 8'h03, 14, 3'h2);
        pc(5'h0A, 8'h0C, 15, 3'h4);
        pc(5'h0C, 8'h30, 16, 3'h3);
        pc(5'h0D, 8'h0C, 19, 3'h3);
        $display("test pin functions done");
        for (int k = 0; k < 4; k++) route(k[0]);
        $display("test input routing done");
        do_reset();
        read_all(1'b1);
        $display("test second reset done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
